// ### bench/spcg_port_model.sv
// Model of the five gated port modules: one bus access at a time.
// Assumes the fault flag is combinational of select and enable.
`timescale 1ns/100ps
`default_nettype none
module spcg_port_model #(
   parameter int NUM_PORTS = 5
) (
   input  wire logic                 core_clk,
   input  wire logic [NUM_PORTS-1:0] port_fault,
   output var logic  [NUM_PORTS-1:0] port_access_sel
);
   initial port_access_sel = '0;
   // Select stands one cycle; fault is taken at the closing edge
   task automatic poke(input int i, output logic f);
      @(posedge core_clk);
      port_access_sel <= NUM_PORTS'(1) << i;
      @(posedge core_clk);
      f = port_fault[i];
      port_access_sel <= '0;
   endtask
endmodule
`default_nettype wire

// ### bench/spcg_sva.sv
// Checker for the sleep port clock gating block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module spcg_sva #(
   parameter int NUM_PORTS = 5
) (
   input wire logic                          core_clk,
   input wire logic                          reset,
   input wire spcg_pkg::spcg_axil_req_type   axil_req,
   input wire spcg_pkg::spcg_axil_rsp_type   axil_rsp,
   input wire spcg_pkg::spcg_power_mode_type power_mode,
   input wire logic [NUM_PORTS-1:0]          port_access_sel,
   input wire logic [NUM_PORTS-1:0]          port_clk_en,
   input wire logic [NUM_PORTS-1:0]          port_fault
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // Mapped words: run, sleep, deep-sleep and run config
   function automatic logic hit(input logic [11:0] a);
      return (a & 12'hFFC) inside {spcg_pkg::SPCG_RUN_GATE_OFF, spcg_pkg::SPCG_SLEEP_GATE_OFF,
                                   spcg_pkg::SPCG_DEEP_GATE_OFF, spcg_pkg::SPCG_RUN_CFG_OFF};
   endfunction
   logic ar_go;
   logic wr_go;
   assign ar_go = axil_req.arvalid && axil_rsp.arready;
   assign wr_go = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
   fault_match_a: assert property (port_fault == (port_access_sel & ~port_clk_en))
      else $error("fault does not match select and enable");
   reset_clear_a: assert property ($past(reset) |-> port_clk_en == '0)
      else $error("enables not clear after reset");
   gate_cause_a: assert property ($changed(port_clk_en) |->
      ($past(axil_rsp.bvalid) && !$past(axil_rsp.bvalid, 2)) ||
      ($past(power_mode) != $past(power_mode, 2))) else $error("enable moved without cause");
   reserved_zero_a: assert property (axil_rsp.rvalid |->
      axil_rsp.rdata[31:28] == 4'h0 && axil_rsp.rdata[26:5] == 22'h0)
      else $error("reserved bits read nonzero");
   rd_ok_a: assert property (ar_go && hit(axil_req.araddr) |=>
      axil_rsp.rvalid && axil_rsp.rresp == spcg_pkg::SPCG_RESP_OKAY) else $error("read refused");
   rd_err_a: assert property (ar_go && !hit(axil_req.araddr) |=> axil_rsp.rvalid &&
      axil_rsp.rresp == spcg_pkg::SPCG_RESP_SLVERR && axil_rsp.rdata == 32'h0)
      else $error("unmapped read accepted");
   wr_ok_a: assert property (wr_go && hit(axil_req.awaddr) |-> ##2
      axil_rsp.bvalid && axil_rsp.bresp == spcg_pkg::SPCG_RESP_OKAY) else $error("write refused");
   wr_err_a: assert property (wr_go && !hit(axil_req.awaddr) |-> ##2
      axil_rsp.bvalid && axil_rsp.bresp == spcg_pkg::SPCG_RESP_SLVERR)
      else $error("unmapped write accepted");
   cover property (wr_go && axil_req.awaddr == 12'h118);
   cover property (port_fault != '0);
   cover property (power_mode == spcg_pkg::SPCG_MODE_SLEEP && port_clk_en != '0);
endmodule
bind spcg_sleep_port_clock_gating spcg_sva #(.NUM_PORTS(NUM_PORTS)) spcg_sva_inst (
   .core_clk(core_clk), .reset(reset), .axil_req(axil_req), .axil_rsp(axil_rsp),
   .power_mode(power_mode), .port_access_sel(port_access_sel),
   .port_clk_en(port_clk_en), .port_fault(port_fault));
`default_nettype wire

// ### bench/test_sleep_port_clock_gating.sv
// Testbench for the sleep port clock gating block.
// Assumes the design, its checker and the port model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_sleep_port_clock_gating;
   logic                          core_clk = 1'h0;
   logic                          reset = 1'h1;
   spcg_pkg::spcg_axil_req_type   req = '0;
   spcg_pkg::spcg_axil_rsp_type   rsp;
   spcg_pkg::spcg_power_mode_type mode = spcg_pkg::SPCG_MODE_RUN;
   logic [4:0]                    sel, en, flt;
   logic [31:0]                   d;
   logic [1:0]                    r;
   logic                          f;
   int                            mismatches = 0, tests_run = 0, cycles = 0;
   always #2 core_clk = ~core_clk;
   spcg_sleep_port_clock_gating spcg_sleep_port_clock_gating_inst (.core_clk(core_clk),
      .reset(reset), .axil_req(req), .axil_rsp(rsp), .power_mode(mode),
      .port_access_sel(sel), .port_clk_en(en), .port_fault(flt));
   spcg_port_model spcg_port_model_inst (.core_clk(core_clk), .port_fault(flt),
      .port_access_sel(sel));
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF);
      @(posedge core_clk);
      req <= '{awvalid:1'h1, awaddr:a, wvalid:1'h1, wdata:v, wstrb:s, bready:1'h1, default:'0};
      do begin
         @(posedge core_clk);
         if (rsp.awready) req.awvalid <= 1'h0;
         if (rsp.wready) req.wvalid <= 1'h0;
      end while (!rsp.bvalid);
      r = rsp.bresp;
      req.bready <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge core_clk);
      req <= '{arvalid:1'h1, araddr:a, rready:1'h1, default:'0};
      do begin
         @(posedge core_clk);
         if (rsp.arready) req.arvalid <= 1'h0;
      end while (!rsp.rvalid);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'h0;
   endtask
   // Enables settle one cycle after the cause
   task automatic ck(input spcg_pkg::spcg_power_mode_type m, input logic [4:0] e);
      @(posedge core_clk);
      mode <= m;
      repeat (2) @(posedge core_clk);
      chk(32'(en), 32'(e));
   endtask
   task automatic t_reset;
      rd(12'h108); chk(d, 32'h0);
      chk(32'(r), 32'h0);
      rd(12'h118); chk(d, 32'h0);
      rd(12'h128); chk(d, 32'h0);
      ck(spcg_pkg::SPCG_MODE_RUN, 5'h00);
      $display("reset test done");
   endtask
   task automatic t_run;
      for (int i = 0; i < 5; i++) begin
         wr(12'h108, 32'h1 << i); chk(32'(r), 32'h0);
         ck(spcg_pkg::SPCG_MODE_RUN, 5'h01 << i);
         spcg_port_model_inst.poke(i, f); chk(32'(f), 32'h0);
         spcg_port_model_inst.poke((i + 1) % 5, f); chk(32'(f), 32'h1);
      end
      wr(12'h108, 32'hFFFFFFFF);
      rd(12'h108); chk(d, 32'h1F);
      $display("run test done");
   endtask
   task automatic t_modes;
      rd(12'h118); wr(12'h118, (d & ~32'h1F) | 32'h0A);
      wr(12'h128, 32'h11);
      wr(12'h108, 32'h04);
      ck(spcg_pkg::SPCG_MODE_SLEEP, 5'h04);
      ck(spcg_pkg::SPCG_MODE_DEEP_SLEEP, 5'h04);
      rd(12'h060); chk(d, 32'h0);
      wr(12'h060, d | 32'h08000000);
      ck(spcg_pkg::SPCG_MODE_SLEEP, 5'h0A);
      ck(spcg_pkg::SPCG_MODE_DEEP_SLEEP, 5'h11);
      ck(spcg_pkg::SPCG_MODE_RUN, 5'h04);
      $display("mode test done");
   endtask
   task automatic t_bad;
      wr(12'h200, 32'hFFFFFFFF); chk(32'(r), 32'h2);
      rd(12'h200); chk(d, 32'h0);
      chk(32'(r), 32'h2);
      wr(12'h118, 32'h1F, 4'hE); chk(32'(r), 32'h0);
      rd(12'h118); chk(d, 32'h0A);
      chk(32'(r), 32'h0);
      $display("unmapped test done");
   endtask
   task automatic t_rst2;
      @(posedge core_clk);
      reset <= 1'h1;
      repeat (3) @(posedge core_clk);
      reset <= 1'h0;
      rd(12'h118); chk(d, 32'h0);
      rd(12'h060); chk(d, 32'h0);
      ck(spcg_pkg::SPCG_MODE_RUN, 5'h00);
      $display("second reset test done");
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'h0;
      t_reset();
      t_run();
      t_modes();
      t_bad();
      t_rst2();
      summarize();
   end
endmodule
`default_nettype wire

// ### pkg/spcg_pkg.sv
// Package for the sleep port clock gating block: offsets, fields, types.
// Assumes a 32-bit AXI4-Lite register bus and five gated port modules.
package spcg_pkg;
   localparam int          SPCG_NUM_PORTS        = 5;
   localparam int          SPCG_ADDR_W           = 12;
   localparam logic [11:0] SPCG_RUN_GATE_OFF     = 12'h108;
   localparam logic [11:0] SPCG_SLEEP_GATE_OFF   = 12'h118;
   localparam logic [11:0] SPCG_DEEP_GATE_OFF    = 12'h128;
   localparam logic [11:0] SPCG_RUN_CFG_OFF      = 12'h060;
   localparam int          SPCG_AUTO_GATE_BIT    = 27;
   localparam int          SPCG_PORT_A_BIT       = 0;
   localparam int          SPCG_PORT_B_BIT       = 1;
   localparam int          SPCG_PORT_C_BIT       = 2;
   localparam int          SPCG_PORT_D_BIT       = 3;
   localparam int          SPCG_PORT_E_BIT       = 4;
   localparam logic [4:0]  SPCG_GATE_RESET       = 5'h00;
   localparam logic [1:0]  SPCG_RESP_OKAY        = 2'h0;
   localparam logic [1:0]  SPCG_RESP_SLVERR      = 2'h2;

   typedef enum logic [1:0] {
      SPCG_MODE_RUN,
      SPCG_MODE_SLEEP,
      SPCG_MODE_DEEP_SLEEP
   } spcg_power_mode_type;

   typedef struct packed {
      logic        awvalid;
      logic [11:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [11:0] araddr;
      logic        rready;
   } spcg_axil_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } spcg_axil_rsp_type;
endpackage

// ### rtl/spcg_port_guard.sv
// Per-port access guard: flags a bus access aimed at an unclocked port.
// Assumes the port fabric reports which port each access selects.
`timescale 1ns/100ps
`default_nettype none
module spcg_port_guard #(
   parameter int NUM_PORTS = 5
) (
   input  wire logic [NUM_PORTS-1:0] port_clk_en,
   input  wire logic [NUM_PORTS-1:0] port_access_sel,
   output logic      [NUM_PORTS-1:0] port_fault
);
   genvar i;
   generate
      for (i = 0; i < NUM_PORTS; i++) begin : g_port
         assign port_fault[i] = port_access_sel[i] & ~port_clk_en[i];
      end
   endgenerate
endmodule
`default_nettype wire

// ### rtl/spcg_sleep_port_clock_gating.sv
// Sleep/run/deep-sleep port clock gating registers on AXI4-Lite.
// Assumes a core clock gate cell per port driven by the enables below.
`timescale 1ns/100ps
`default_nettype none
module spcg_sleep_port_clock_gating #(
   parameter int NUM_PORTS = spcg_pkg::SPCG_NUM_PORTS
) (
   input  wire logic                          core_clk,
   input  wire logic                          reset,
   input  wire spcg_pkg::spcg_axil_req_type   axil_req,
   output var spcg_pkg::spcg_axil_rsp_type    axil_rsp,
   input  wire spcg_pkg::spcg_power_mode_type power_mode,
   input  wire logic [NUM_PORTS-1:0]          port_access_sel,
   output logic      [NUM_PORTS-1:0]          port_clk_en,
   output logic      [NUM_PORTS-1:0]          port_fault
);
   typedef struct packed {
      logic [NUM_PORTS-1:0] run_port_clock_gate;
      logic [NUM_PORTS-1:0] sleep_port_clock_gate;
      logic [NUM_PORTS-1:0] deep_sleep_port_clock_gate;
      logic                 auto_gating_select;
      logic                 aw_held;
      logic [11:0]          aw_addr;
      logic                 w_held;
      logic [31:0]          w_data;
      logic [3:0]           w_strb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      logic [NUM_PORTS-1:0] clk_en;
   } spcg_state_type;

   spcg_state_type       state;
   spcg_state_type       next_state;
   logic [NUM_PORTS-1:0] gate_sel;
   logic [NUM_PORTS-1:0] sleep_src;
   logic [NUM_PORTS-1:0] deep_src;
   logic [NUM_PORTS-1:0] wr_bits;
   logic                 wr_fire;
   logic                 rd_fire;
   logic [11:0]          wr_word;
   logic [11:0]          rd_word;
   logic                 wr_run_hit;
   logic                 wr_sleep_hit;
   logic                 wr_deep_hit;
   logic                 wr_cfg_hit;
   logic                 wr_lane0;
   logic                 wr_mapped;
   logic                 rd_mapped;
   logic [31:0]          rd_value;

   spcg_port_guard #(
      .NUM_PORTS(NUM_PORTS)
   ) u_guard (
      .port_clk_en    (state.clk_en),
      .port_access_sel(port_access_sel),
      .port_fault     (port_fault)
   );

   // Per port: with auto select off both low-power modes keep the run values
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_src
         assign sleep_src[p] = state.auto_gating_select ? state.sleep_port_clock_gate[p]
                                                        : state.run_port_clock_gate[p];
         assign deep_src[p]  = state.auto_gating_select ? state.deep_sleep_port_clock_gate[p]
                                                        : state.run_port_clock_gate[p];
      end
   endgenerate

   // Pick the gating set for the current power mode
   always_comb begin
      case (power_mode)
         spcg_pkg::SPCG_MODE_RUN:
            gate_sel = state.run_port_clock_gate;
         spcg_pkg::SPCG_MODE_SLEEP:
            gate_sel = sleep_src;
         spcg_pkg::SPCG_MODE_DEEP_SLEEP:
            gate_sel = deep_src;
         default:
            gate_sel = state.run_port_clock_gate;
      endcase
   end

   // A write commits once both beats are held and the last answer is gone
   assign wr_fire = state.aw_held & state.w_held & ~state.bvalid;
   assign rd_fire = axil_req.arvalid & ~state.rvalid;

   // Decode ignores the byte offset within a word
   assign wr_word  = state.aw_addr & 12'hFFC;
   assign rd_word  = axil_req.araddr & 12'hFFC;
   assign wr_lane0 = state.w_strb[0];

   always_comb begin
      wr_run_hit   = (wr_word == spcg_pkg::SPCG_RUN_GATE_OFF);
      wr_sleep_hit = (wr_word == spcg_pkg::SPCG_SLEEP_GATE_OFF);
      wr_deep_hit  = (wr_word == spcg_pkg::SPCG_DEEP_GATE_OFF);
      wr_cfg_hit   = (wr_word == spcg_pkg::SPCG_RUN_CFG_OFF);
      wr_mapped    = wr_run_hit | wr_sleep_hit | wr_deep_hit | wr_cfg_hit;
   end

   // Read data mux; unmapped words answer zero with an error
   always_comb begin
      rd_value  = 32'h0000_0000;
      rd_mapped = 1'b1;
      case (rd_word)
         spcg_pkg::SPCG_RUN_GATE_OFF: begin
            rd_value[NUM_PORTS-1:0] = state.run_port_clock_gate;
         end
         spcg_pkg::SPCG_SLEEP_GATE_OFF: begin
            rd_value[NUM_PORTS-1:0] = state.sleep_port_clock_gate;
         end
         spcg_pkg::SPCG_DEEP_GATE_OFF: begin
            rd_value[NUM_PORTS-1:0] = state.deep_sleep_port_clock_gate;
         end
         spcg_pkg::SPCG_RUN_CFG_OFF: begin
            rd_value[spcg_pkg::SPCG_AUTO_GATE_BIT] = state.auto_gating_select;
         end
         default: begin
            rd_mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_state = state;
      next_state.clk_en = gate_sel;
      // Only whole low byte lane carries the port bits
      wr_bits = state.w_strb[0] ? state.w_data[NUM_PORTS-1:0] : '0;
      if (axil_req.awvalid && !state.aw_held) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = axil_req.awaddr;
      end
      if (axil_req.wvalid && !state.w_held) begin
         next_state.w_held = 1'b1;
         next_state.w_data = axil_req.wdata;
         next_state.w_strb = axil_req.wstrb;
      end
      if (wr_fire) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = wr_mapped ? spcg_pkg::SPCG_RESP_OKAY
                                        : spcg_pkg::SPCG_RESP_SLVERR;
         // Clear lane 0 strobe leaves the port bits as they were
         if (wr_run_hit && wr_lane0) begin
            next_state.run_port_clock_gate = wr_bits;
         end
         if (wr_sleep_hit && wr_lane0) begin
            next_state.sleep_port_clock_gate = wr_bits;
         end
         if (wr_deep_hit && wr_lane0) begin
            next_state.deep_sleep_port_clock_gate = wr_bits;
         end
         if (wr_cfg_hit && state.w_strb[3]) begin
            next_state.auto_gating_select = state.w_data[spcg_pkg::SPCG_AUTO_GATE_BIT];
         end
      end
      if (state.bvalid && axil_req.bready) begin
         next_state.bvalid = 1'b0;
      end
      if (rd_fire) begin
         next_state.rvalid = 1'b1;
         next_state.rdata  = rd_value;
         next_state.rresp  = rd_mapped ? spcg_pkg::SPCG_RESP_OKAY
                                       : spcg_pkg::SPCG_RESP_SLVERR;
      end else if (state.rvalid && axil_req.rready) begin
         next_state.rvalid = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
         state.run_port_clock_gate        <= NUM_PORTS'(spcg_pkg::SPCG_GATE_RESET);
         state.sleep_port_clock_gate      <= NUM_PORTS'(spcg_pkg::SPCG_GATE_RESET);
         state.deep_sleep_port_clock_gate <= NUM_PORTS'(spcg_pkg::SPCG_GATE_RESET);
      end else begin
         state <= next_state;
      end
   end

   // Holding registers accept one address and one data beat each
   always_comb begin
      axil_rsp.awready = ~state.aw_held;
      axil_rsp.wready  = ~state.w_held;
      axil_rsp.bvalid  = state.bvalid;
      axil_rsp.bresp   = state.bresp;
      axil_rsp.arready = ~state.rvalid;
      axil_rsp.rvalid  = state.rvalid;
      axil_rsp.rdata   = state.rdata;
      axil_rsp.rresp   = state.rresp;
   end

   assign port_clk_en = state.clk_en;
endmodule
`default_nettype wire
